//--- rtl/srcv_pkg.sv
package srcv_pkg;

	// =====================================================================
	// Register indices (byte address is four times the index)
	localparam logic [5:0] IDX_GEN_CTRL   = 6'h00;
	localparam logic [5:0] IDX_CAL_CLK    = 6'h01;
	localparam logic [5:0] IDX_AMP_DELAY  = 6'h04;
	localparam logic [5:0] IDX_FORCE_CTRL = 6'h08;
	localparam logic [5:0] IDX_DOUBLER    = 6'h09;
	localparam logic [5:0] IDX_REF_MULTIPLIER       = 6'h0A;
	localparam logic [5:0] IDX_POST_DIV   = 6'h0B;
	localparam logic [5:0] IDX_PRE_DIV    = 6'h0C;
	localparam logic [5:0] IDX_PUMP       = 6'h0E;
	localparam logic [5:0] IDX_FORCED_AMP = 6'h10;
	localparam logic [5:0] IDX_START_AMP  = 6'h11;
	localparam logic [5:0] IDX_FORCED_BND = 6'h13;
	localparam logic [5:0] IDX_CORE_SEL   = 6'h14;
	localparam logic [5:0] IDX_CAL_STATUS = 6'h15;

	// =====================================================================
	// Field positions
	localparam int CAL_TRIG_BIT   = 3;
	localparam int DOUBLER_BIT    = 12;
	localparam int AMP_FORCE_BIT  = 14;
	localparam int BAND_FORCE_BIT = 11;
	localparam int CORE_FORCE_BIT = 10;
	localparam int REF_MULTIPLIER_LSB       = 7;
	localparam int POST_DIV_LSB   = 4;
	localparam int PUMP_LSB       = 4;
	localparam int DELAY_LSB      = 8;
	localparam int CORE_LSB       = 11;

	// =====================================================================
	// Reset images, fixed bits included
	localparam logic [15:0] RST_GEN_CTRL   = 16'h2410;
	localparam logic [15:0] RST_CAL_CLK    = 16'h080B;
	localparam logic [15:0] RST_AMP_DELAY  = 16'h0A43;
	localparam logic [15:0] RST_FORCE_CTRL = 16'h2000;
	localparam logic [15:0] RST_DOUBLER    = 16'h0604;
	localparam logic [15:0] RST_REF_MULTIPLIER       = 16'h10D8;
	localparam logic [15:0] RST_POST_DIV   = 16'h0018;
	localparam logic [15:0] RST_PRE_DIV    = 16'h5001;
	localparam logic [15:0] RST_PUMP       = 16'h1E70;
	localparam logic [15:0] RST_FORCED_AMP = 16'h0080;
	localparam logic [15:0] RST_START_AMP  = 16'h00FA;
	localparam logic [15:0] RST_FORCED_BND = 16'h27B7;
	localparam logic [15:0] RST_CORE_SEL   = 16'hF848;

	// =====================================================================
	// Writable field masks; other bits hold fixed values
	localparam logic [15:0] WM_GEN_CTRL   = 16'h0008;
	localparam logic [15:0] WM_CAL_CLK    = 16'h0007;
	localparam logic [15:0] WM_AMP_DELAY  = 16'hFF00;
	localparam logic [15:0] WM_FORCE_CTRL = 16'h4800;
	localparam logic [15:0] WM_DOUBLER    = 16'h1000;
	localparam logic [15:0] WM_REF_MULTIPLIER       = 16'h0F80;
	localparam logic [15:0] WM_POST_DIV   = 16'h0FF0;
	localparam logic [15:0] WM_PRE_DIV    = 16'h0FFF;
	localparam logic [15:0] WM_PUMP       = 16'h0070;
	localparam logic [15:0] WM_AMP9       = 16'h01FF;
	localparam logic [15:0] WM_FORCED_BND = 16'h00FF;
	localparam logic [15:0] WM_CORE_SEL   = 16'h3C00;

	// =====================================================================
	// Calibration sequencer limits: band steps in divided calibration clock ticks, last core code
	localparam logic [7:0] BAND_STEPS = 8'h08;
	localparam logic [2:0] CORE_LAST  = 3'h7;

	// Calibration sequencer states
	typedef enum logic [4:0]
	{
		ST_IDLE  = 5'b00001,
		ST_CORE  = 5'b00010,
		ST_BAND  = 5'b00100,
		ST_AMP   = 5'b01000,
		ST_DONE  = 5'b10000
	} srcv_state_t;

endpackage : srcv_pkg

//--- rtl/srcv_cal_if.sv
`timescale 1ns/1ps
// Settings and handshake between the register bank and the sequencer
interface srcv_cal_if;
	logic        start;
	logic [2:0]  clk_div;
	logic [7:0]  amp_delay;
	logic        amp_force;
	logic        band_force;
	logic        core_force;
	logic [8:0]  forced_amp;
	logic [8:0]  start_amp;
	logic [7:0]  forced_band;
	logic [2:0]  core_sel;
	logic        busy;

	modport bank (output start, clk_div, amp_delay, amp_force, band_force,
		core_force, forced_amp, start_amp, forced_band, core_sel,
		input busy);
	modport seq (input start, clk_div, amp_delay, amp_force, band_force,
		core_force, forced_amp, start_amp, forced_band, core_sel,
		output busy);
endinterface : srcv_cal_if

//--- rtl/srcv_tick_div.sv
`timescale 1ns/1ps
// =====================================================================
// Calibration clock tick: one pulse every 1, 2, 4 or 8 clocks
module srcv_tick_div
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	// Divider code and tick
	input  wire logic [2:0] div_code,
	output logic            tick
);
	logic [2:0] cnt_ff;
	logic [2:0] nxt_cnt;
	logic [2:0] lim;

	// Codes above 3 saturate at divide by 8
	always_comb
	begin
		lim = (div_code > 3'h3) ? 3'h7 : 3'((4'h1 << div_code) - 4'h1);
		nxt_cnt = (cnt_ff >= lim) ? 3'h0 : cnt_ff + 3'h1;
		tick = (cnt_ff >= lim);
	end

	// Free-running counter
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			cnt_ff <= 3'h0;
		else
			cnt_ff <= nxt_cnt;
	end

	// R16 divide by 8 at code 3 gives a tick each eighth clock
	a_tick_spacing: assert property (@(posedge clk) disable iff (!rstn) // R16
		(div_code == 3'h3 && tick) ##1 (div_code == 3'h3)[*7] |=> tick)
		else $error("tick spacing wrong at divide by 8");
endmodule : srcv_tick_div

//--- rtl/srcv_regs.sv
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
// Notes on behaviour
// R1: doubler enable bit 12 of the doubler register, resets to 0.
// R2: multiplier bits 11:7, codes 1, 3, 7 valid; others reserved; reset 1.
// R3: post-divider bits 11:4 follow the multiplier, reset 1.
// R4: pre-divider bits 11:0 precede the multiplier, reset 1.
// R5: pump current code bits 6:4, codes 2 and 6 reserved, reset 7.
// R6: software keeps amplitude delay at or above 10, its reset value.
// R7: delay should exceed calibration clock frequency over 10 MHz.
// R8: when calibration time matters, software uses delay of 25 or more.
// R9: amplitude force bit 14 skips amplitude search, uses forced code.
// R10: forced amplitude code bits 8:0, reset 128.
// R11: starting amplitude code bits 8:0, reset 250.
// R12: band force bit 11 skips band search, uses forced band.
// R13: forced band bits 7:0, reset 183.
// R14: core select bits 13:11, start or forced core, reset 7.
// R15: core force bit 10 pins the chosen core; diagnostic, reset 0.
// R16: calibration clock divider code 0..3 means 1, 2, 4, 8; reset 3.
// R17: writing 1 to the trigger bit launches a calibration.
// R18: software writes fixed bits with their layout values.
module srcv_regs
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Analog settings
	output logic             ref_doubler_en,
	output logic [4:0]       ref_multiplier,
	output logic             ref_ref_multiplier_reserved,
	output logic [7:0]       ref_post_div,
	output logic [11:0]      ref_pre_div,
	output logic [2:0]       pump_current_code,
	output logic             pump_code_reserved,
	// Calibration results
	output logic [2:0]       vco_core,
	output logic [7:0]       vco_band,
	output logic [8:0]       vco_amp,
	output logic             cal_busy
);
	localparam int NREG = 13;

	// =====================================================================
	// Register storage
	logic [15:0] regs_ff [NREG];
	logic [15:0] nxt_regs [NREG];
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;
	logic        trig_ff;
	logic        nxt_trig;
	logic        wr_en;
	logic        rd_en;
	logic        hit;
	logic [4:0]  dec;
	logic [3:0]  sel;
	logic [8:0]  res_amp;
	logic [7:0]  res_band;
	logic [2:0]  res_core;

	srcv_cal_if cal ();

	// Per-slot constants, in slot order
	localparam logic [5:0] IDX [NREG] = '{
		srcv_pkg::IDX_GEN_CTRL, srcv_pkg::IDX_CAL_CLK,
		srcv_pkg::IDX_AMP_DELAY, srcv_pkg::IDX_FORCE_CTRL,
		srcv_pkg::IDX_DOUBLER, srcv_pkg::IDX_REF_MULTIPLIER,
		srcv_pkg::IDX_POST_DIV, srcv_pkg::IDX_PRE_DIV,
		srcv_pkg::IDX_PUMP, srcv_pkg::IDX_FORCED_AMP,
		srcv_pkg::IDX_START_AMP, srcv_pkg::IDX_FORCED_BND,
		srcv_pkg::IDX_CORE_SEL};
	localparam logic [15:0] RST [NREG] = '{
		srcv_pkg::RST_GEN_CTRL, srcv_pkg::RST_CAL_CLK,
		srcv_pkg::RST_AMP_DELAY, srcv_pkg::RST_FORCE_CTRL,
		srcv_pkg::RST_DOUBLER, srcv_pkg::RST_REF_MULTIPLIER,
		srcv_pkg::RST_POST_DIV, srcv_pkg::RST_PRE_DIV,
		srcv_pkg::RST_PUMP, srcv_pkg::RST_FORCED_AMP,
		srcv_pkg::RST_START_AMP, srcv_pkg::RST_FORCED_BND,
		srcv_pkg::RST_CORE_SEL};
	localparam logic [15:0] WM [NREG] = '{
		srcv_pkg::WM_GEN_CTRL, srcv_pkg::WM_CAL_CLK,
		srcv_pkg::WM_AMP_DELAY, srcv_pkg::WM_FORCE_CTRL,
		srcv_pkg::WM_DOUBLER, srcv_pkg::WM_REF_MULTIPLIER,
		srcv_pkg::WM_POST_DIV, srcv_pkg::WM_PRE_DIV,
		srcv_pkg::WM_PUMP, srcv_pkg::WM_AMP9,
		srcv_pkg::WM_AMP9, srcv_pkg::WM_FORCED_BND,
		srcv_pkg::WM_CORE_SEL};

	// Word-aligned index decode, used for reads and writes
	function automatic logic [4:0] decode(input logic [7:0] a);
		logic [4:0] r;
		r = 5'h1F;
		if (a[1:0] == 2'h0)
			for (int i = 0; i < NREG; i++)
				if (a[7:2] == IDX[i])
					r = 5'(i);
		return r;
	endfunction : decode

	// =====================================================================
	// APB decode; zero wait states
	always_comb
	begin
		dec = decode(paddr);
		sel = dec[3:0];
		hit = (dec != 5'h1F);
		wr_en = psel && penable && pwrite && hit;
		rd_en = psel && !penable && !pwrite;
		pready = 1'b1;
		pslverr = psel && penable && !hit
			&& (paddr[7:2] != srcv_pkg::IDX_CAL_STATUS || pwrite);
	end

	// Next register values; only documented fields are writable
	always_comb
	begin
		for (int i = 0; i < NREG; i++)
			nxt_regs[i] = regs_ff[i];
		nxt_trig = 1'b0;
		if (wr_en)
		begin
			nxt_regs[sel] = (regs_ff[sel] & ~WM[sel])
				| (pwdata[15:0] & WM[sel]);
			// Writing 1 to the trigger launches calibration
			nxt_trig = (sel == 4'h0) && pwdata[srcv_pkg::CAL_TRIG_BIT]; // R17
		end
	end

	// Read data captured in setup, stable through access
	always_comb
	begin
		nxt_prdata = prdata_ff;
		if (rd_en)
		begin
			if (paddr[7:2] == srcv_pkg::IDX_CAL_STATUS && paddr[1:0] == 2'h0)
				nxt_prdata = {7'h00, cal.busy, 1'b0, res_core,
					res_band, 3'h0, res_amp};
			else if (hit)
				nxt_prdata = {16'h0000, regs_ff[sel]};
			else
				nxt_prdata = 32'h0000_0000;
		end
	end

	// Storage with reset images
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < NREG; i++)
				regs_ff[i] <= RST[i]; // R1 R2 R3 R4 R5 R10 R11 R13 R14 R16
			trig_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end
		else
		begin
			for (int i = 0; i < NREG; i++)
				regs_ff[i] <= nxt_regs[i];
			trig_ff <= nxt_trig;
			prdata_ff <= nxt_prdata;
		end
	end

	// =====================================================================
	// Analog settings straight from the flops
	always_comb
	begin
		ref_doubler_en = regs_ff[4][srcv_pkg::DOUBLER_BIT]; // R1
		ref_multiplier = regs_ff[5][srcv_pkg::REF_MULTIPLIER_LSB +: 5]; // R2
		// Reserved codes are flagged, not blocked; software must avoid them
		ref_ref_multiplier_reserved = !(ref_multiplier == 5'h01
			|| ref_multiplier == 5'h03 || ref_multiplier == 5'h07); // R2
		ref_post_div = regs_ff[6][srcv_pkg::POST_DIV_LSB +: 8]; // R3
		ref_pre_div = regs_ff[7][11:0]; // R4
		pump_current_code = regs_ff[8][srcv_pkg::PUMP_LSB +: 3]; // R5
		pump_code_reserved = (pump_current_code == 3'h2)
			|| (pump_current_code == 3'h6); // R5
		prdata = prdata_ff;
		vco_core = res_core;
		vco_band = res_band;
		vco_amp = res_amp;
		cal_busy = cal.busy;
	end

	// Settings handed to the calibration sequencer
	always_comb
	begin
		cal.start = trig_ff; // R17
		cal.clk_div = regs_ff[1][2:0]; // R16
		cal.amp_delay = regs_ff[2][srcv_pkg::DELAY_LSB +: 8];
		cal.amp_force = regs_ff[3][srcv_pkg::AMP_FORCE_BIT]; // R9
		cal.band_force = regs_ff[3][srcv_pkg::BAND_FORCE_BIT]; // R12
		cal.core_force = regs_ff[12][srcv_pkg::CORE_FORCE_BIT]; // R15
		cal.forced_amp = regs_ff[9][8:0]; // R10
		cal.start_amp = regs_ff[10][8:0]; // R11
		cal.forced_band = regs_ff[11][7:0]; // R13
		cal.core_sel = regs_ff[12][srcv_pkg::CORE_LSB +: 3]; // R14
	end

	// =====================================================================
	// Calibration sequencer
	srcv_cal_seq u_seq
	(
		.clk      (clk),
		.rstn     (rstn),
		.cal      (cal.seq),
		.res_core (res_core),
		.res_band (res_band),
		.res_amp  (res_amp)
	);

	// =====================================================================
	// Checks
	a_doubler_write: assert property (@(posedge clk) disable iff (!rstn) // R1
		wr_en && sel == 4'h4 |=> ref_doubler_en == $past(pwdata[12]))
		else $error("doubler enable not written");
	a_ref_multiplier_write: assert property (@(posedge clk) disable iff (!rstn) // R2
		wr_en && sel == 4'h5 |=> ref_multiplier == $past(pwdata[11:7]))
		else $error("multiplier field not written");
	a_post_div_write: assert property (@(posedge clk) // R3
		disable iff (!rstn)
		wr_en && sel == 4'h6 |=> ref_post_div == $past(pwdata[11:4]))
		else $error("post divider not written");
	a_pre_div_hold: assert property (@(posedge clk) disable iff (!rstn) // R4
		!(wr_en && sel == 4'h7) |=> $stable(ref_pre_div))
		else $error("pre divider changed without write");
	a_pump_reserved: assert property (@(posedge clk) // R5
		disable iff (!rstn)
		pump_current_code == 3'h6 |-> pump_code_reserved)
		else $error("reserved pump code not flagged");
	a_trigger_launch: assert property (@(posedge clk) // R17
		disable iff (!rstn)
		wr_en && sel == 4'h0 && pwdata[3] && !cal.busy
		|=> ##1 cal.busy)
		else $error("trigger write did not start calibration");
endmodule : srcv_regs

//--- rtl/srcv_cal_seq.sv
`timescale 1ns/1ps
// =====================================================================
// Calibration sequencer: core, band, then amplitude settle
module srcv_cal_seq
(
	// Clock and reset
	input  wire logic  clk,
	input  wire logic  rstn,
	// Settings and status
	srcv_cal_if.seq    cal,
	// Results
	output logic [2:0] res_core,
	output logic [7:0] res_band,
	output logic [8:0] res_amp
);
	srcv_pkg::srcv_state_t st_ff;
	srcv_pkg::srcv_state_t nxt_st;
	logic [7:0] cnt_ff;
	logic [7:0] nxt_cnt;
	logic [2:0] core_ff;
	logic [2:0] nxt_core;
	logic [7:0] band_ff;
	logic [7:0] nxt_band;
	logic [8:0] amp_ff;
	logic [8:0] nxt_amp;
	logic       tick;

	// Divided clock pacing the whole sequence
	srcv_tick_div u_div
	(
		.clk      (clk),
		.rstn     (rstn),
		.div_code (cal.clk_div), // R16
		.tick     (tick)
	);

	// Next state; a new trigger during a run restarts it
	always_comb
	begin
		nxt_st = st_ff;
		nxt_cnt = cnt_ff;
		nxt_core = core_ff;
		nxt_band = band_ff;
		nxt_amp = amp_ff;
		if (cal.start)
		begin
			nxt_st = srcv_pkg::ST_CORE;
			nxt_core = (cal.core_sel == 3'h0) ? 3'h1 : cal.core_sel; // R14
			nxt_cnt = 8'h00;
		end
		else if (tick)
		begin
			case (st_ff)
				srcv_pkg::ST_IDLE:
					nxt_st = srcv_pkg::ST_IDLE;
				srcv_pkg::ST_CORE:
				begin
					// Forced core stays put; otherwise step up by one core, holding at 7
					if (!cal.core_force && core_ff != srcv_pkg::CORE_LAST) // R15
						nxt_core = core_ff + 3'h1;
					nxt_st = srcv_pkg::ST_BAND;
					nxt_band = cal.band_force ? cal.forced_band : 8'h00; // R12 R13
				end
				srcv_pkg::ST_BAND:
				begin
					if (cal.band_force || cnt_ff == srcv_pkg::BAND_STEPS) // R12
					begin
						nxt_st = srcv_pkg::ST_AMP;
						nxt_cnt = 8'h00;
						nxt_amp = cal.amp_force ? cal.forced_amp
							: cal.start_amp; // R9 R10 R11
					end
					else
					begin
						nxt_cnt = cnt_ff + 8'h01;
						nxt_band = band_ff + 8'h10;
					end
				end
				srcv_pkg::ST_AMP:
				begin
					// Amplitude settles over the programmed delay
					if (cal.amp_force || cnt_ff >= cal.amp_delay) // R9
						nxt_st = srcv_pkg::ST_DONE;
					else
						nxt_cnt = cnt_ff + 8'h01;
				end
				srcv_pkg::ST_DONE:
					nxt_st = srcv_pkg::ST_IDLE;
				default:
					nxt_st = srcv_pkg::ST_IDLE;
			endcase
		end
	end

	// State registers
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st_ff <= srcv_pkg::ST_IDLE;
			cnt_ff <= 8'h00;
			core_ff <= srcv_pkg::RST_CORE_SEL[13:11];
			band_ff <= srcv_pkg::RST_FORCED_BND[7:0];
			amp_ff <= srcv_pkg::RST_FORCED_AMP[8:0];
		end
		else
		begin
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			core_ff <= nxt_core;
			band_ff <= nxt_band;
			amp_ff <= nxt_amp;
		end
	end

	// Results and busy
	always_comb
	begin
		res_core = core_ff;
		res_band = band_ff;
		res_amp = amp_ff;
		cal.busy = (st_ff != srcv_pkg::ST_IDLE);
	end

	a_forced_amp_used: assert property (@(posedge clk) // R9
		disable iff (!rstn)
		st_ff == srcv_pkg::ST_BAND && nxt_st == srcv_pkg::ST_AMP
		&& cal.amp_force && !cal.start |=> res_amp == $past(cal.forced_amp))
		else $error("forced amplitude not applied");
	a_core_forced: assert property (@(posedge clk) disable iff (!rstn) // R15
		st_ff == srcv_pkg::ST_CORE && cal.core_force && !cal.start
		|=> $stable(res_core))
		else $error("forced core moved");
endmodule : srcv_cal_seq

//--- testbench/srcv_regs_tb.sv
`timescale 1ns/1ps
// =====================================================================
// Self-checking bench for the synthesizer register bank
module srcv_regs_tb;
	// Clock, reset and APB
	logic        clk;
	logic        rstn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	// Settings and results
	logic        ref_doubler_en;
	logic [4:0]  ref_multiplier;
	logic        ref_ref_multiplier_reserved;
	logic [7:0]  ref_post_div;
	logic [11:0] ref_pre_div;
	logic [2:0]  pump_current_code;
	logic        pump_code_reserved;
	logic [2:0]  vco_core;
	logic [7:0]  vco_band;
	logic [8:0]  vco_amp;
	logic        cal_busy;
	// Bookkeeping
	int          fails;
	int          cmp_count;
	logic [31:0] rd;
	logic        er;
	int          d1;
	int          d2;

	// =====================================================================
	// Device under test
	srcv_regs DUT
	(
		.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr),
		.ref_doubler_en(ref_doubler_en), .ref_multiplier(ref_multiplier),
		.ref_ref_multiplier_reserved(ref_ref_multiplier_reserved), .ref_post_div(ref_post_div),
		.ref_pre_div(ref_pre_div), .pump_current_code(pump_current_code),
		.pump_code_reserved(pump_code_reserved), .vco_core(vco_core),
		.vco_band(vco_band), .vco_amp(vco_amp), .cal_busy(cal_busy)
	);

	// Free-running 25 MHz clock
	initial clk = 1'b0;
	always #20 clk = ~clk;

	// =====================================================================
	// Compare, bus and run-control tasks
	task cmp(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	// One APB transfer; waits for pready, settles at the falling edge
	task apb(input logic w, input logic [5:0] idx, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the slave
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(negedge clk);
	endtask : apb

	task wr(input logic [5:0] idx, input logic [31:0] d);
		apb(1'b1, idx, d);
		cmp("pslverr write", 32'h0, {31'h0, er});
	endtask : wr

	task rdchk(input string what, input logic [5:0] idx,
		input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		cmp(what, exp, rd);
	endtask : rdchk

	// Trigger a calibration, return its busy length in clocks
	task run_cal(output int cyc);
		int n;
		wr(srcv_pkg::IDX_GEN_CTRL, 32'h0000_0008);
		n = 0;
		// Busy is sampled mid-cycle, where it has settled
		while (cal_busy !== 1'b1 && n < 10)
		begin
			@(negedge clk);
			n++;
		end
		cmp("busy rise", 32'h1, {31'h0, cal_busy});
		cyc = 0;
		while (cal_busy !== 1'b0 && cyc < 3000)
		begin
			@(negedge clk);
			cyc++;
		end
		@(negedge clk);
		cmp("busy fall", 32'h0, {31'h0, cal_busy});
	endtask : run_cal

	task conclude;
		$display("Comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude

	// =====================================================================
	// Scenarios
	task test_reset;
		rdchk("delay", srcv_pkg::IDX_AMP_DELAY, 32'h0A43);
		rdchk("force", srcv_pkg::IDX_FORCE_CTRL, 32'h2000);
		rdchk("doubler", srcv_pkg::IDX_DOUBLER, 32'h0604);
		rdchk("ref_multiplier", srcv_pkg::IDX_REF_MULTIPLIER, 32'h10D8);
		rdchk("post", srcv_pkg::IDX_POST_DIV, 32'h0018);
		rdchk("pre", srcv_pkg::IDX_PRE_DIV, 32'h5001);
		rdchk("pump", srcv_pkg::IDX_PUMP, 32'h1E70);
		rdchk("famp", srcv_pkg::IDX_FORCED_AMP, 32'h0080);
		rdchk("samp", srcv_pkg::IDX_START_AMP, 32'h00FA);
		rdchk("fband", srcv_pkg::IDX_FORCED_BND, 32'h27B7);
		rdchk("core", srcv_pkg::IDX_CORE_SEL, 32'hF848);
		rdchk("clkdiv", srcv_pkg::IDX_CAL_CLK, 32'h080B);
		cmp("pre port", 32'h1, {20'h0, ref_pre_div});
		cmp("post port", 32'h1, {24'h0, ref_post_div});
		cmp("band res", 32'd183, {24'h0, vco_band});
		cmp("amp res", 32'd128, {23'h0, vco_amp});
		$display("test reset done");
	endtask : test_reset

	// All ones, then zeros to the doubler; fixed bits must keep their layout values
	task test_fields;
		wr(srcv_pkg::IDX_DOUBLER, 32'hFFFF_FFFF);
		wr(srcv_pkg::IDX_POST_DIV, 32'hFFFF_FFFF);
		wr(srcv_pkg::IDX_PRE_DIV, 32'hFFFF_FFFF);
		rdchk("doubler ones", srcv_pkg::IDX_DOUBLER, 32'h1604);
		rdchk("post ones", srcv_pkg::IDX_POST_DIV, 32'h0FF8);
		rdchk("pre ones", srcv_pkg::IDX_PRE_DIV, 32'h5FFF);
		cmp("doubler on", 32'h1, {31'h0, ref_doubler_en});
		cmp("post max", 32'hFF, {24'h0, ref_post_div});
		cmp("pre max", 32'hFFF, {20'h0, ref_pre_div});
		wr(srcv_pkg::IDX_DOUBLER, 32'h0);
		wr(srcv_pkg::IDX_CORE_SEL, 32'hFFFF_FFFF);
		wr(srcv_pkg::IDX_START_AMP, 32'hFFFF_FFFF);
		rdchk("core ones", srcv_pkg::IDX_CORE_SEL, 32'hFC48);
		rdchk("samp ones", srcv_pkg::IDX_START_AMP, 32'h01FF);
		rdchk("doubler off", srcv_pkg::IDX_DOUBLER, 32'h0604);
		cmp("doubler port", 32'h0, {31'h0, ref_doubler_en});
		wr(srcv_pkg::IDX_CORE_SEL, 32'h0000_3800);
		wr(srcv_pkg::IDX_START_AMP, 32'd250);
		$display("test fields done");
	endtask : test_fields

	// Multiplier codes 0 to 8 and every pump code, reserved ones flagged
	task test_codes;
		for (int c = 0; c < 9; c++)
		begin
			wr(srcv_pkg::IDX_REF_MULTIPLIER, 32'(c) << 7);
			cmp("ref_multiplier code", 32'(c), {27'h0, ref_multiplier});
			cmp("ref_multiplier rsv", 32'(!(c == 1 || c == 3 || c == 7)),
				{31'h0, ref_ref_multiplier_reserved});
		end
		for (int c = 0; c < 8; c++)
		begin
			wr(srcv_pkg::IDX_PUMP, 32'(c) << 4);
			cmp("pump code", 32'(c), {29'h0, pump_current_code});
			cmp("pump rsv", 32'(c == 2 || c == 6),
				{31'h0, pump_code_reserved});
		end
		$display("test codes done");
	endtask : test_codes

	// Unmapped word and read-only status are refused
	task test_refuse;
		apb(1'b0, 6'h02, 32'h0);
		cmp("unmapped err", 32'h1, {31'h0, er});
		cmp("unmapped data", 32'h0, rd);
		apb(1'b1, srcv_pkg::IDX_CAL_STATUS, 32'hFFFF_FFFF);
		cmp("status err", 32'h1, {31'h0, er});
		$display("test refuse done");
	endtask : test_refuse

	// Forced calibration at two clock dividers, then delay dependence
	task test_cal;
		wr(srcv_pkg::IDX_CAL_CLK, 32'h0);
		wr(srcv_pkg::IDX_FORCE_CTRL, 32'h4800);
		wr(srcv_pkg::IDX_FORCED_AMP, 32'h0155);
		wr(srcv_pkg::IDX_FORCED_BND, 32'h005A);
		wr(srcv_pkg::IDX_CORE_SEL, 32'h1C00);
		run_cal(d1);
		cmp("core forced", 32'h3, {29'h0, vco_core});
		cmp("band forced", 32'h5A, {24'h0, vco_band});
		cmp("amp forced", 32'h155, {23'h0, vco_amp});
		rdchk("status", srcv_pkg::IDX_CAL_STATUS, 32'h0035_A155);
		rdchk("trigger", srcv_pkg::IDX_GEN_CTRL, 32'h2418);
		wr(srcv_pkg::IDX_CAL_CLK, 32'h3);
		wr(srcv_pkg::IDX_CORE_SEL, 32'h2C00);
		run_cal(d2);
		cmp("core div8", 32'h5, {29'h0, vco_core});
		cmp("div8 slower", 32'h1, {31'h0, d2 > 4 * d1});
		wr(srcv_pkg::IDX_CAL_CLK, 32'h0);
		wr(srcv_pkg::IDX_FORCE_CTRL, 32'h0800);
		run_cal(d1);
		cmp("amp start", 32'd250, {23'h0, vco_amp});
		// Delay 40 keeps the floor and the fast-calibration minimum
		wr(srcv_pkg::IDX_AMP_DELAY, 32'h2843);
		run_cal(d2);
		cmp("delay span", 32'd30, 32'(d2 - d1));
		$display("test cal done");
	endtask : test_cal

	// =====================================================================
	// Main sequence and watchdog
	initial
	begin
		fails = 0;
		cmp_count = 0;
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		test_reset;
		test_fields;
		test_codes;
		test_refuse;
		test_cal;
		conclude;
	end

	// Whole run is a few hundred clocks; reaching 50000 clocks means a hang
	initial
	begin
		#(40 * 50000);
		fails++;
		conclude;
	end
endmodule : srcv_regs_tb
